// file: core/mcod_table.v
`timescale 1ns/1ps
`include "mcod_defs.vh"
// ****************************************
// Opcode table: class, length, cycles
// ****************************************
module mcod_table (
  input  wire [7:0]               i_opcode,
  output reg  [`MCOD_CLS_W-1:0]   o_cls,
  output reg  [`MCOD_ALU_W-1:0]   o_alu,
  output reg  [`MCOD_SRC_W-1:0]   o_src,
  output reg  [1:0]               o_bytes,
  output reg  [1:0]               o_cycles
);
  wire [3:0] hi = i_opcode[7:4];
  wire [3:0] lo = i_opcode[3:0];

  always @* begin
    o_cls    = `MCOD_CLS_ILLEGAL;
    o_alu    = `MCOD_ALU_NONE;
    o_src    = `MCOD_SRC_NONE;
    o_bytes  = 2'd1;
    o_cycles = 2'd1;
    if (i_opcode[4:0] == 5'h11) begin
      o_cls = `MCOD_CLS_CALL;
      o_bytes = 2'd2;
      o_cycles = 2'd2;
    end else if (i_opcode[4:0] == 5'h01) begin
      o_cls = `MCOD_CLS_JUMP;
      o_bytes = 2'd2;
      o_cycles = 2'd2;
    end else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) && lo >= 4'h2) begin
      o_alu = (hi == 4'h4) ? `MCOD_ALU_OR : (hi == 4'h5) ? `MCOD_ALU_AND : `MCOD_ALU_XOR;
      o_cls = (lo <= 4'h3) ? `MCOD_CLS_LOGIC_D : `MCOD_CLS_LOGIC_A;
      if (lo >= 4'h8) begin
        o_src = `MCOD_SRC_REG;
      end else if (lo >= 4'h6) begin
        o_src = `MCOD_SRC_IND;
      end else if (lo == 4'h5) begin
        o_src = `MCOD_SRC_DIR;
        o_bytes = 2'd2;
      end else if (lo == 4'h4) begin
        o_src = `MCOD_SRC_IMM;
        o_bytes = 2'd2;
      end else if (lo == 4'h3) begin
        o_src = `MCOD_SRC_IMM;
        o_bytes = 2'd3;
        o_cycles = 2'd2;
      end else begin
        o_src = `MCOD_SRC_ACC;
        o_bytes = 2'd2;
      end
    end else begin
      case (i_opcode)
        8'h00: o_cls = `MCOD_CLS_NOP;
        8'h23, 8'h33, 8'h03, 8'h13: begin
          o_cls = `MCOD_CLS_ROTATE;
          o_alu = (i_opcode == 8'h23) ? `MCOD_ALU_RL : (i_opcode == 8'h33) ? `MCOD_ALU_RLC :
                  (i_opcode == 8'h03) ? `MCOD_ALU_RR : `MCOD_ALU_RRC;
        end
        8'hc4: begin
          o_cls = `MCOD_CLS_SWAP;
          o_alu = `MCOD_ALU_SWAP;
        end
        8'he4, 8'hf4: begin
          o_cls = `MCOD_CLS_LOGIC_A;
          o_alu = (i_opcode == 8'he4) ? `MCOD_ALU_CLR : `MCOD_ALU_CPL;
        end
        8'h90: begin
          o_cls = `MCOD_CLS_LOAD_DP;
          o_src = `MCOD_SRC_IMM;
          o_bytes = 2'd3;
          o_cycles = 2'd2;
        end
        8'he0, 8'he2, 8'he3: begin
          o_cls = `MCOD_CLS_XRD;
          o_src = lo[1] ? `MCOD_SRC_IND : `MCOD_SRC_NONE;
          o_cycles = 2'd2;
        end
        8'hf0, 8'hf2, 8'hf3: begin
          o_cls = `MCOD_CLS_XWR;
          o_src = lo[1] ? `MCOD_SRC_IND : `MCOD_SRC_NONE;
          o_cycles = 2'd2;
        end
        8'h93, 8'h83: begin
          o_cls = `MCOD_CLS_CODE_RD;
          o_cycles = 2'd2;
        end
        8'hc0, 8'hd0: begin
          o_cls = (i_opcode == 8'hc0) ? `MCOD_CLS_PUSH : `MCOD_CLS_POP;
          o_src = `MCOD_SRC_DIR;
          o_bytes = 2'd2;
          o_cycles = 2'd2;
        end
        8'hc6, 8'hc7: begin
          o_cls = `MCOD_CLS_XCH;
          o_src = `MCOD_SRC_IND;
        end
        8'hd6, 8'hd7: begin
          o_cls = `MCOD_CLS_XCHD;
          o_src = `MCOD_SRC_IND;
        end
        8'h12, 8'h02: begin
          o_cls = (i_opcode == 8'h12) ? `MCOD_CLS_CALL : `MCOD_CLS_JUMP;
          o_bytes = 2'd3;
          o_cycles = 2'd2;
        end
        8'h22, 8'h32: begin
          o_cls = `MCOD_CLS_RET;
          o_cycles = 2'd2;
        end
        8'h80: begin
          o_cls = `MCOD_CLS_JUMP;
          o_bytes = 2'd2;
          o_cycles = 2'd2;
        end
        8'h73: begin
          o_cls = `MCOD_CLS_JMP_IND;
          o_cycles = 2'd2;
        end
        8'h60, 8'h70: begin
          o_cls = (i_opcode == 8'h60) ? `MCOD_CLS_JZ : `MCOD_CLS_JNZ;
          o_bytes = 2'd2;
          o_cycles = 2'd2;
        end
        8'h40, 8'h50: begin
          o_cls = `MCOD_CLS_JC;
          o_alu = (i_opcode == 8'h40) ? `MCOD_ALU_SET : `MCOD_ALU_CLR;
          o_bytes = 2'd2;
          o_cycles = 2'd2;
        end
        8'h10, 8'h20, 8'h30: begin
          o_cls = `MCOD_CLS_JBIT;
          o_alu = (i_opcode == 8'h30) ? `MCOD_ALU_CLR : `MCOD_ALU_SET;
          o_src = `MCOD_SRC_DIR;
          o_bytes = 2'd3;
          o_cycles = 2'd2;
        end
        8'hb4, 8'hb5, 8'hb6, 8'hb7: begin
          o_cls = `MCOD_CLS_CJNE;
          o_src = (lo == 4'h5) ? `MCOD_SRC_DIR : (lo == 4'h4) ? `MCOD_SRC_ACC : `MCOD_SRC_IND;
          o_bytes = 2'd3;
          o_cycles = 2'd2;
        end
        8'hd5: begin
          o_cls = `MCOD_CLS_DJNZ;
          o_src = `MCOD_SRC_DIR;
          o_bytes = 2'd3;
          o_cycles = 2'd2;
        end
        8'h82, 8'hb0, 8'h72, 8'ha0: begin
          o_cls = `MCOD_CLS_BIT_C;
          o_alu = (i_opcode == 8'h82) ? `MCOD_ALU_AND : (i_opcode == 8'hb0) ? `MCOD_ALU_ANDN :
                  (i_opcode == 8'h72) ? `MCOD_ALU_OR : `MCOD_ALU_ORN;
          o_src = `MCOD_SRC_DIR;
          o_bytes = 2'd2;
          o_cycles = 2'd2;
        end
        8'h92, 8'ha2: begin
          o_cls = `MCOD_CLS_BIT_OP;
          o_src = (i_opcode == 8'h92) ? `MCOD_SRC_CARRY : `MCOD_SRC_DIR;
          o_bytes = 2'd2;
          o_cycles = (i_opcode == 8'h92) ? 2'd2 : 2'd1;
        end
        8'hc2, 8'hd2, 8'hb2, 8'hc3, 8'hd3, 8'hb3: begin
          o_cls = `MCOD_CLS_BIT_OP;
          o_alu = (hi == 4'hc) ? `MCOD_ALU_CLR : (hi == 4'hd) ? `MCOD_ALU_SET : `MCOD_ALU_CPL;
          o_src = lo[0] ? `MCOD_SRC_CARRY : `MCOD_SRC_DIR;
          o_bytes = lo[0] ? 2'd1 : 2'd2;
        end
        default: begin
          if (hi == 4'ha && lo >= 4'h8) begin
            o_cls = `MCOD_CLS_MOV;
            o_src = `MCOD_SRC_DIR;
            o_bytes = 2'd2;
            o_cycles = 2'd2;
          end else if (hi == 4'hb && lo >= 4'h8) begin
            o_cls = `MCOD_CLS_CJNE;
            o_src = `MCOD_SRC_REG;
            o_bytes = 2'd3;
            o_cycles = 2'd2;
          end else if (hi == 4'hd && lo >= 4'h8) begin
            o_cls = `MCOD_CLS_DJNZ;
            o_src = `MCOD_SRC_REG;
            o_bytes = 2'd2;
            o_cycles = 2'd2;
          end else if (hi == 4'hc && lo >= 4'h8) begin
            o_cls = `MCOD_CLS_XCH;
            o_src = `MCOD_SRC_REG;
          end
        end
      endcase
    end
  end
endmodule // mcod_table

// file: common/mcod_defs.vh
`ifndef MCOD_DEFS_VH
`define MCOD_DEFS_VH
// ****************************************
// Operation classes
// ****************************************
`define MCOD_CLS_W         5
`define MCOD_CLS_NOP       5'h00
`define MCOD_CLS_LOGIC_A   5'h01
`define MCOD_CLS_LOGIC_D   5'h02
`define MCOD_CLS_ROTATE    5'h03
`define MCOD_CLS_SWAP      5'h04
`define MCOD_CLS_MOV       5'h05
`define MCOD_CLS_LOAD_DP   5'h06
`define MCOD_CLS_XRD       5'h07
`define MCOD_CLS_XWR       5'h08
`define MCOD_CLS_CODE_RD   5'h09
`define MCOD_CLS_PUSH      5'h0a
`define MCOD_CLS_POP       5'h0b
`define MCOD_CLS_XCH       5'h0c
`define MCOD_CLS_XCHD      5'h0d
`define MCOD_CLS_CALL      5'h0e
`define MCOD_CLS_JUMP      5'h0f
`define MCOD_CLS_JMP_IND   5'h10
`define MCOD_CLS_JZ        5'h11
`define MCOD_CLS_JNZ       5'h12
`define MCOD_CLS_JBIT      5'h13
`define MCOD_CLS_CJNE      5'h14
`define MCOD_CLS_DJNZ      5'h15
`define MCOD_CLS_BIT_C     5'h16
`define MCOD_CLS_BIT_OP    5'h17
`define MCOD_CLS_RET       5'h18
`define MCOD_CLS_JC        5'h19
`define MCOD_CLS_ILLEGAL   5'h1f
// ****************************************
// ALU sub-operations
// ****************************************
`define MCOD_ALU_W         4
`define MCOD_ALU_NONE      4'h0
`define MCOD_ALU_AND       4'h1
`define MCOD_ALU_OR        4'h2
`define MCOD_ALU_XOR       4'h3
`define MCOD_ALU_RL        4'h4
`define MCOD_ALU_RLC       4'h5
`define MCOD_ALU_RR        4'h6
`define MCOD_ALU_RRC       4'h7
`define MCOD_ALU_CLR       4'h8
`define MCOD_ALU_SET       4'h9
`define MCOD_ALU_CPL       4'ha
`define MCOD_ALU_ANDN      4'hb
`define MCOD_ALU_ORN       4'hc
`define MCOD_ALU_SWAP      4'hd
// ****************************************
// Operand sources
// ****************************************
`define MCOD_SRC_W         3
`define MCOD_SRC_NONE      3'h0
`define MCOD_SRC_REG       3'h1
`define MCOD_SRC_DIR       3'h2
`define MCOD_SRC_IND       3'h3
`define MCOD_SRC_IMM       3'h4
`define MCOD_SRC_ACC       3'h5
`define MCOD_SRC_CARRY     3'h6
// ****************************************
// Reset values
// ****************************************
`define MCOD_RST_OPCODE    8'h00
`define MCOD_RST_PC        16'h0000
`endif

// file: core/mcod_decoder.v
`timescale 1ns/1ps
`include "mcod_defs.vh"
module mcod_decoder (
  input  wire                     i_ref_clk,
  input  wire                     i_reset,
  input  wire                     i_clk_en,
  input  wire [7:0]               i_code_byte,
  input  wire                     i_code_valid,
  output wire                     o_code_req,
  output reg  [15:0]              o_pc_r,
  output reg  [7:0]               o_opcode_r,
  output reg  [7:0]               o_operand1_r,
  output reg  [7:0]               o_operand2_r,
  output reg  [`MCOD_CLS_W-1:0]   o_cls_r,
  output reg  [`MCOD_ALU_W-1:0]   o_alu_r,
  output reg  [`MCOD_SRC_W-1:0]   o_src_r,
  output reg  [2:0]               o_reg_sel_r,
  output reg  [1:0]               o_bytes_r,
  output reg  [1:0]               o_cycle_r,
  output reg                      o_exec_r,
  output reg                      o_done_r,
  output reg                      o_illegal_r
);
  // ****************************************
  // Sequencer states
  // ****************************************
  localparam [3:0] ST_FETCH = 4'b0001;
  localparam [3:0] ST_OPND1 = 4'b0010;
  localparam [3:0] ST_OPND2 = 4'b0100;
  localparam [3:0] ST_EXEC  = 4'b1000;

  reg  [3:0]             state_r;
  reg  [3:0]             state_nxt;
  reg  [1:0]             cycles_r;
  wire [`MCOD_CLS_W-1:0] t_cls;
  wire [`MCOD_ALU_W-1:0] t_alu;
  wire [`MCOD_SRC_W-1:0] t_src;
  wire [1:0]             t_bytes;
  wire [1:0]             t_cycles;

  mcod_table u_table (
    .i_opcode (i_code_byte),
    .o_cls    (t_cls),
    .o_alu    (t_alu),
    .o_src    (t_src),
    .o_bytes  (t_bytes),
    .o_cycles (t_cycles)
  );

  // Code bytes are requested only while gathering the instruction
  assign o_code_req = (state_r != ST_EXEC);
  wire take = i_clk_en & i_code_valid & o_code_req;

  // ****************************************
  // Next state
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_FETCH: if (take) state_nxt = (t_bytes > 2'd1) ? ST_OPND1 : ST_EXEC;
      ST_OPND1: if (take) state_nxt = (o_bytes_r > 2'd2) ? ST_OPND2 : ST_EXEC;
      ST_OPND2: if (take) state_nxt = ST_EXEC;
      ST_EXEC:  if (o_cycle_r == cycles_r) state_nxt = ST_FETCH;
      default:  state_nxt = ST_FETCH;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r      <= ST_FETCH;
      o_pc_r       <= `MCOD_RST_PC;
      o_opcode_r   <= `MCOD_RST_OPCODE;
      o_operand1_r <= 8'h00;
      o_operand2_r <= 8'h00;
      o_cls_r      <= `MCOD_CLS_NOP;
      o_alu_r      <= `MCOD_ALU_NONE;
      o_src_r      <= `MCOD_SRC_NONE;
      o_reg_sel_r  <= 3'h0;
      o_bytes_r    <= 2'd1;
      o_cycle_r    <= 2'd0;
      cycles_r     <= 2'd1;
      o_exec_r     <= 1'b0;
      o_done_r     <= 1'b0;
      o_illegal_r  <= 1'b0;
    end else if (i_clk_en) begin
      state_r  <= state_nxt;
      o_done_r <= 1'b0;
      // PC steps once per code byte taken, so it is past all bytes before exec
      if (take) begin
        o_pc_r <= o_pc_r + 16'h0001;
      end
      case (state_r)
        ST_FETCH: if (take) begin
          o_opcode_r  <= i_code_byte;
          o_cls_r     <= t_cls;
          o_alu_r     <= t_alu;
          o_src_r     <= t_src;
          o_bytes_r   <= t_bytes;
          cycles_r    <= t_cycles;
          o_reg_sel_r <= i_code_byte[2:0];
          o_illegal_r <= (t_cls == `MCOD_CLS_ILLEGAL);
          o_cycle_r   <= 2'd1;
          o_exec_r    <= (t_bytes == 2'd1);
        end
        ST_OPND1: if (take) begin
          o_operand1_r <= i_code_byte;
          o_exec_r     <= (o_bytes_r == 2'd2);
        end
        ST_OPND2: if (take) begin
          o_operand2_r <= i_code_byte;
          o_exec_r     <= 1'b1;
        end
        ST_EXEC: begin
          if (o_cycle_r == cycles_r) begin
            o_exec_r  <= 1'b0;
            o_done_r  <= 1'b1;
            o_cycle_r <= 2'd0;
          end else begin
            o_cycle_r <= o_cycle_r + 2'd1;
          end
        end
        default: o_exec_r <= 1'b0;
      endcase
    end
  end
endmodule // mcod_decoder

// file: bench/mcod_decoder_sva.sv
`timescale 1ns/1ps
`include "mcod_defs.vh"
module mcod_chk (
  input wire                   i_ref_clk,
  input wire                   i_reset,
  input wire                   i_clk_en,
  input wire [7:0]             i_code_byte,
  input wire                   i_code_valid,
  input wire                   o_code_req,
  input wire [15:0]            o_pc_r,
  input wire [7:0]             o_opcode_r,
  input wire [7:0]             o_operand1_r,
  input wire [7:0]             o_operand2_r,
  input wire [`MCOD_CLS_W-1:0] o_cls_r,
  input wire [`MCOD_ALU_W-1:0] o_alu_r,
  input wire [`MCOD_SRC_W-1:0] o_src_r,
  input wire [2:0]             o_reg_sel_r,
  input wire [1:0]             o_bytes_r,
  input wire [1:0]             o_cycle_r,
  input wire                   o_exec_r,
  input wire                   o_done_r,
  input wire                   o_illegal_r
);
  // ****************************************
  // Sequencing and decode checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_done_after_exec: assert property ($fell(o_exec_r) |-> o_done_r)
    else $error("done missing after execute");
  a_done_pulse: assert property (o_done_r && i_clk_en |=> !o_done_r)
    else $error("done longer than one cycle");
  a_no_fetch_exec: assert property (o_exec_r |-> !o_code_req)
    else $error("fetch requested during execute");
  a_pc_step: assert property (i_clk_en && i_code_valid && o_code_req
    |=> o_pc_r == $past(o_pc_r) + 16'h1) else $error("pc did not step on byte");
  a_pc_hold: assert property (!(i_clk_en && i_code_valid && o_code_req)
    |=> $stable(o_pc_r)) else $error("pc moved without a byte");
  a_freeze_state: assert property (!i_clk_en
    |=> $stable(o_exec_r) && $stable(o_cycle_r)) else $error("state moved while frozen");
  a_first_cycle: assert property ($rose(o_exec_r) |-> o_cycle_r == 2'h1)
    else $error("execute did not start at cycle one");
  a_dp_load_len: assert property (o_exec_r && o_opcode_r == 8'h90
    |-> o_bytes_r == 2'h3 && o_cls_r == `MCOD_CLS_LOAD_DP) else $error("pointer load wrong");
  a_ext_two_cyc: assert property ($rose(o_exec_r) && i_clk_en && (o_opcode_r inside
    {8'he0, 8'he2, 8'hf0, 8'hf3, 8'h93, 8'h73}) |=> o_exec_r && o_cycle_r == 2'h2)
    else $error("two-cycle op ended early");
  a_acc_one_cyc: assert property ($rose(o_exec_r) && i_clk_en && (o_opcode_r inside
    {8'h23, 8'h13, 8'hc4, 8'hc2, 8'hb3, 8'ha2}) |=> !o_exec_r)
    else $error("one-cycle op ran long");
  a_reg_index: assert property (o_exec_r |-> o_reg_sel_r == o_opcode_r[2:0])
    else $error("register index wrong");
endmodule // mcod_chk
bind mcod_decoder mcod_chk mcod_chk_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_clk_en(i_clk_en), .i_code_byte(i_code_byte), .i_code_valid(i_code_valid),
  .o_code_req(o_code_req), .o_pc_r(o_pc_r), .o_opcode_r(o_opcode_r),
  .o_operand1_r(o_operand1_r), .o_operand2_r(o_operand2_r), .o_cls_r(o_cls_r),
  .o_alu_r(o_alu_r), .o_src_r(o_src_r), .o_reg_sel_r(o_reg_sel_r), .o_bytes_r(o_bytes_r),
  .o_cycle_r(o_cycle_r), .o_exec_r(o_exec_r), .o_done_r(o_done_r),
  .o_illegal_r(o_illegal_r));

// file: bench/tb_mcod_decoder.sv
`timescale 1ns/1ps
`include "mcod_defs.vh"
module tb_mcod_decoder;
  reg                    i_ref_clk;
  reg                    i_reset;
  reg                    i_clk_en;
  reg  [7:0]             i_code_byte;
  reg                    i_code_valid;
  wire                   o_code_req;
  wire [15:0]            o_pc_r;
  wire [7:0]             o_opcode_r;
  wire [7:0]             o_operand1_r;
  wire [7:0]             o_operand2_r;
  wire [`MCOD_CLS_W-1:0] o_cls_r;
  wire [`MCOD_ALU_W-1:0] o_alu_r;
  wire [`MCOD_SRC_W-1:0] o_src_r;
  wire [2:0]             o_reg_sel_r;
  wire [1:0]             o_bytes_r;
  wire [1:0]             o_cycle_r;
  wire                   o_exec_r;
  wire                   o_done_r;
  wire                   o_illegal_r;
  integer                fail_count;
  integer                comparisons;

  mcod_decoder mcod_decoder_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_code_byte(i_code_byte), .i_code_valid(i_code_valid), .o_code_req(o_code_req),
    .o_pc_r(o_pc_r), .o_opcode_r(o_opcode_r), .o_operand1_r(o_operand1_r),
    .o_operand2_r(o_operand2_r), .o_cls_r(o_cls_r), .o_alu_r(o_alu_r), .o_src_r(o_src_r),
    .o_reg_sel_r(o_reg_sel_r), .o_bytes_r(o_bytes_r), .o_cycle_r(o_cycle_r),
    .o_exec_r(o_exec_r), .o_done_r(o_done_r), .o_illegal_r(o_illegal_r));

  always #2.5 i_ref_clk = ~i_ref_clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Entry: opcode, bytes, cycles, class (ff skips), sub-op (f skips)
  task run(input [27:0] e);
    reg [15:0] pc0;
    integer    k;
    begin
      pc0 = o_pc_r;
      for (k = 0; k < e[19:16]; k = k + 1) begin
        @(posedge i_ref_clk);
        i_code_byte  <= (k == 0) ? e[27:20] : 8'h40 + k[7:0];
        i_code_valid <= 1'b1;
      end
      for (k = 1; k <= e[15:12]; k = k + 1) begin
        @(posedge i_ref_clk);
        i_code_byte <= 8'ha5;  // Left valid so a refused byte would show in pc
        #1;
        chk(o_exec_r, 16'h1);
        chk(o_cycle_r, k[15:0]);
        chk(o_code_req, 16'h0);
      end
      @(posedge i_ref_clk);
      i_code_valid <= 1'b0;
      #1;
      chk({o_exec_r, o_done_r}, 16'h1);
      chk(o_code_req, 16'h1);
      chk(o_illegal_r, {15'h0, e[11:4] == 8'h1f});
      chk(o_pc_r, pc0 + {12'h0, e[19:16]});
      chk({o_opcode_r, 3'h0, o_reg_sel_r, o_bytes_r}, {e[27:20], 3'h0, e[22:20], e[17:16]});
      if (e[19:16] > 4'h1)
        chk(o_operand1_r, 16'h41);
      if (e[19:16] > 4'h2)
        chk(o_operand2_r, 16'h42);
      if (e[11:4] != 8'hff)
        chk(o_cls_r, e[11:4]);
      if (e[3:0] != 4'hf)
        chk(o_alu_r, e[3:0]);
    end
  endtask

  task rule_set(input [167:0] list, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
        run(list[28*i +: 28]);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_logic;
    begin
      rule_set({28'h5811011, 28'h5f11011}, 2);
      rule_set({28'h5332021}, 1);
      rule_set({28'h4811012, 28'h4521012, 28'h4611012, 28'h4421012}, 4);
      rule_set({28'h6332023, 28'h6221023}, 2);
      rule_set({28'h2311034, 28'h3311035, 28'h0311036, 28'h1311037}, 4);
      rule_set({28'hc41104d}, 1);
      rule_set({28'he411018, 28'hf41101a, 28'hc8110cf}, 3);
    end
  endtask

  task t_transfer;
    begin
      rule_set({28'ha82205f, 28'haf2205f}, 2);
      rule_set({28'h903206f}, 1);
      rule_set({28'he21207f, 28'he31207f, 28'hf21208f, 28'hf31208f}, 4);
      rule_set({28'he01207f, 28'hf01208f}, 2);
      rule_set({28'h931209f, 28'h831209f}, 2);
      rule_set({28'hc0220af, 28'hd0220bf}, 2);
      rule_set({28'hd6110df, 28'hd7110df, 28'hc6110cf}, 3);
    end
  endtask

  task t_branch;
    begin
      rule_set({28'h11220ef, 28'hf1220ef, 28'h01220ff, 28'he1220ff}, 4);
      rule_set({28'h731210f}, 1);
      rule_set({28'h602211f, 28'h702212f}, 2);
      rule_set({28'h1032139, 28'h203213f, 28'h3032138}, 3);
      rule_set({28'hb43214f, 28'hb53214f, 28'hbf3214f, 28'hb73214f}, 4);
      rule_set({28'hd82215f, 28'hdf2215f, 28'hd53215f}, 3);
      rule_set({28'h12320ef, 28'h02320ff, 28'h80220ff, 28'h221218f, 28'h4022199, 28'h5022198}, 6);
    end
  endtask

  task t_boolean;
    begin
      rule_set({28'h8222161, 28'hb02216b, 28'h7222162, 28'ha02216c}, 4);
      rule_set({28'h922217f, 28'ha22117f}, 2);
      rule_set({28'hc221178, 28'hd221179, 28'hb22117a}, 3);
      rule_set({28'hc311178, 28'hd311179, 28'hb31117a}, 3);
    end
  endtask

  // Source field stands until the next opcode, so it is read after the run
  task src_case(input [27:0] e, input [2:0] s);
    begin
      run(e);
      chk(o_src_r, {13'h0, s});
    end
  endtask

  task t_sources;
    begin
      src_case(28'h5811011, `MCOD_SRC_REG);
      src_case(28'h4521012, `MCOD_SRC_DIR);
      src_case(28'h4611012, `MCOD_SRC_IND);
      src_case(28'h4421012, `MCOD_SRC_IMM);
      src_case(28'h6221023, `MCOD_SRC_ACC);
      src_case(28'he21207f, `MCOD_SRC_IND);
      src_case(28'he01207f, `MCOD_SRC_NONE);
      src_case(28'hd6110df, `MCOD_SRC_IND);
      src_case(28'hbf3214f, `MCOD_SRC_REG);
      src_case(28'h922217f, `MCOD_SRC_CARRY);
      src_case(28'ha22117f, `MCOD_SRC_DIR);
      src_case(28'hc311178, `MCOD_SRC_CARRY);
    end
  endtask

  // Unlisted opcode is flagged and still takes one byte, one cycle
  task t_illegal;
    begin
      run(28'h24111ff);
    end
  endtask

  // Clock enable low must hold off a byte that is on offer
  task t_freeze;
    reg [15:0] pc0;
    begin
      pc0 = o_pc_r;
      @(posedge i_ref_clk);
      i_clk_en     <= 1'b0;
      i_code_byte  <= 8'h90;
      i_code_valid <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk(o_exec_r, 16'h0);
      chk(o_pc_r, pc0);
      @(posedge i_ref_clk);
      i_clk_en     <= 1'b1;
      i_code_valid <= 1'b0;
      #1;
    end
  endtask

  task print_verdict;
    begin
      if (fail_count == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #20000;
    fail_count = fail_count + 1;
    print_verdict;
  end

  initial begin
    i_ref_clk    = 1'b0;
    i_reset      = 1'b1;
    i_clk_en     = 1'b1;
    i_code_byte  = 8'h00;
    i_code_valid = 1'b0;
    fail_count   = 0;
    comparisons  = 0;
    repeat (12) @(posedge i_ref_clk);
    #1;
    chk(o_code_req, 16'h1);
    chk(o_pc_r, 16'h0);
    chk(o_bytes_r, 16'h1);
    @(posedge i_ref_clk);
    i_reset <= 1'b0;
    #1;
    t_logic;
    t_freeze;
    t_transfer;
    t_branch;
    t_boolean;
    t_sources;
    t_illegal;
    print_verdict;
  end
endmodule // tb_mcod_decoder
